// file: hdl/lpmrs_pkg.sv
// package of constants and carrier types for the low power mode and reset source controller
package lpmrs_pkg;

  // ************************************************************
  // register byte offsets on the axi4-lite bus
  // ************************************************************
  localparam logic [7:0] LPMRS_CTRL_OFF = 8'h00;  // osc_irq_enable, delay select readback
  localparam logic [7:0] LPMRS_STAT_OFF = 8'h04;  // mode and reset cause flags
  localparam logic [7:0] LPMRS_IRQ_STAT_OFF = 8'h08;  // sticky event bits
  localparam logic [7:0] LPMRS_IRQ_CLR_OFF = 8'h0C;  // write one to clear
  localparam logic [7:0] LPMRS_IRQ_EN_OFF = 8'h10;  // interrupt enables
  localparam logic [7:0] LPMRS_FLAG_CLR_OFF = 8'h14;  // write one to clear reset flags

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int LPMRS_CTRL_OIE_BIT = 0;  // osc_irq_enable
  localparam int LPMRS_FLAG_LVD_BIT = 0;  // low_voltage_reset_flag
  localparam int LPMRS_FLAG_WDG_BIT = 1;  // watchdog_reset_flag
  localparam int LPMRS_EV_HALT_BIT = 0;  // entered plain halt
  localparam int LPMRS_EV_AHALT_BIT = 1;  // entered active halt
  localparam int LPMRS_EV_WAKE_BIT = 2;  // woke by interrupt
  localparam int LPMRS_EV_RST_BIT = 3;  // reset pin driven
  localparam int LPMRS_EV_W = 4;

  // ************************************************************
  // reset values and timing
  // ************************************************************
  localparam logic LPMRS_CTRL_OIE_RST = 1'b0;
  localparam logic [1:0] LPMRS_CC_I_ACTIVE = 2'b10;  // interrupts enabled
  localparam int LPMRS_DELAY_SHORT_CYC = 256;  // cpu cycles
  localparam int LPMRS_DELAY_LONG_CYC = 4096;  // cpu cycles
  localparam int LPMRS_RST_PULSE_NS = 500;  // reset_out_min_pulse, plain default
  localparam int LPMRS_CLK_NS = 25;
  localparam int LPMRS_RST_PULSE_CYC = (LPMRS_RST_PULSE_NS + LPMRS_CLK_NS - 1) / LPMRS_CLK_NS;
  localparam int LPMRS_CNT_W = 13;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    LPMRS_RUN = 3'b000,
    LPMRS_HALT = 3'b001,
    LPMRS_AHALT = 3'b010,
    LPMRS_DELAY = 3'b011,
    LPMRS_DHALT = 3'b100
  } lpmrs_mode_t;

  // wake and reset sources from the rest of the chip
  typedef struct packed {
    logic halt_exec;  // core executes halt
    logic rtc_irq;  // main_clock_rtc_unit interrupt
    logic ext_irq;  // wake-capable interrupt
    logic wdg_underflow;  // watchdog counter underflow
    logic wdg_active;  // watchdog running
    logic lvd_low;  // low_voltage_detector below threshold
  } lpmrs_src_t;

  // clock and core controls
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic rtc_clk_en;
    logic cc_force;  // force condition_code_reg interrupt bits
    logic [1:0] cc_i_val;
    logic wdg_block;  // suppress watchdog reset in active halt
    logic service_irq;  // resume by servicing the wake interrupt
    logic fetch_reset;  // resume at reset vector
  } lpmrs_ctl_t;

endpackage

// file: hdl/lpmrs_ctrl.sv
// low power mode, wake-up delay and reset source controller with axi4-lite registers
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module lpmrs_ctrl
  import lpmrs_pkg::*;
#(
  parameter int RST_PULSE_CYC = LPMRS_RST_PULSE_CYC
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // option byte straps
  input wire logic opt_lvd_en,
  input wire logic opt_long_delay,
  // event sources
  input wire lpmrs_src_t src,
  // external reset pin, open drain
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  // core and clock controls
  output lpmrs_ctl_t ctl,
  output logic irq,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ************************************************************
  // state carrier
  // ************************************************************
  typedef struct packed {
    lpmrs_mode_t mode;  // power mode
    logic [LPMRS_CNT_W-1:0] cnt;  // delay counter
    logic [LPMRS_CNT_W-1:0] pulse;  // reset pulse counter
    logic [2:0] pin_sync;  // reset pin synchroniser
    logic pin_low;  // filtered pin level is low
    logic osc_irq_enable;  // osc_irq_enable
    logic lvd_flag;  // low_voltage_reset_flag
    logic wdg_flag;  // watchdog_reset_flag
    logic wake_irq;  // last wake was an interrupt
    logic [LPMRS_EV_W-1:0] ev_stat;  // sticky events
    logic [LPMRS_EV_W-1:0] ev_en;  // event enables
    logic aw_got;  // write address held
    logic w_got;  // write data held
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic strap_done;  // option delay latched
    logic long_delay;  // latched delay choice
  } lpmrs_state_t;

  lpmrs_state_t st_reg;
  lpmrs_state_t st_next;

  // delay length in cycles for the current option
  function automatic logic [LPMRS_CNT_W-1:0] delay_len(input logic long_sel);
    delay_len = long_sel ? LPMRS_CNT_W'(LPMRS_DELAY_LONG_CYC - 1)
                         : LPMRS_CNT_W'(LPMRS_DELAY_SHORT_CYC - 1);
  endfunction

  // aligned word address match
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    addr_is = (a[7:2] == off[7:2]);
  endfunction

  // internal request for a reset pulse
  logic wdg_rst_req;
  logic lvd_rst_req;
  logic do_write;
  logic [31:0] wd;
  logic [LPMRS_EV_W-1:0] ev_set;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    st_next = st_reg;
    ev_set = '0;
    wd = '0;
    // watchdog suppressed while in active halt with oie set
    // mask watchdog reset
    wdg_rst_req = src.wdg_underflow && src.wdg_active
                  && !((st_reg.mode == LPMRS_AHALT) && st_reg.osc_irq_enable);
    lvd_rst_req = opt_lvd_en && src.lvd_low;

    // strap caught once after reset release, then static
    // latch option delay
    if (!st_reg.strap_done)
    begin
      st_next.strap_done = 1'b1;
      st_next.long_delay = opt_long_delay;
    end

    // external pin: three flops, change counts when last two agree
    st_next.pin_sync = {st_reg.pin_sync[1:0], rst_pin_in};
    if (st_reg.pin_sync[2] == st_reg.pin_sync[1])
      st_next.pin_low = !st_reg.pin_sync[2];

    // reset pulse generation holds pin low for at least the minimum
    if (wdg_rst_req || lvd_rst_req)
    begin
      st_next.pulse = LPMRS_CNT_W'(RST_PULSE_CYC);
      ev_set[LPMRS_EV_RST_BIT] = 1'b1;
      if (lvd_rst_req)
        st_next.lvd_flag = 1'b1;
      // flag only meaningful with detector on
      if (wdg_rst_req && opt_lvd_en)
        st_next.wdg_flag = 1'b1;
    end
    else if (st_reg.pulse != '0)
      st_next.pulse = st_reg.pulse - 1'b1;

    // power mode sequencing
    case (st_reg.mode)
      LPMRS_RUN:
      begin
        if (src.halt_exec)
        begin
          if (st_reg.osc_irq_enable)
          begin
            st_next.mode = LPMRS_AHALT;
            ev_set[LPMRS_EV_AHALT_BIT] = 1'b1;
          end
          else
          begin
            st_next.mode = LPMRS_HALT;
            ev_set[LPMRS_EV_HALT_BIT] = 1'b1;
          end
        end
      end
      LPMRS_HALT:
      begin
        // plain halt wakes on a wake interrupt or a reset, not on rtc; rtc is stopped
        if (src.ext_irq)
        begin
          st_next.mode = LPMRS_DELAY;
          st_next.cnt = delay_len(st_reg.long_delay);
          st_next.wake_irq = 1'b1;
        end
      end
      LPMRS_AHALT:
      begin
        if (src.rtc_irq || src.ext_irq)
        begin
          st_next.mode = LPMRS_RUN;
          st_next.wake_irq = 1'b1;
          st_next.cnt = delay_len(st_reg.long_delay);
          ev_set[LPMRS_EV_WAKE_BIT] = 1'b1;
        end
      end
      LPMRS_DELAY, LPMRS_DHALT:
      begin
        if (st_reg.cnt == '0)
        begin
          st_next.mode = LPMRS_RUN;
          ev_set[LPMRS_EV_WAKE_BIT] = st_reg.wake_irq;
        end
        else
          st_next.cnt = st_reg.cnt - 1'b1;
      end
      default:
        st_next.mode = LPMRS_RUN;
    endcase

    // oie cleared early after an interrupt wake: halt for rest of window
    // drop into halt
    if ((st_reg.mode == LPMRS_RUN) && st_reg.wake_irq && (st_reg.cnt != '0))
    begin
      st_next.cnt = st_reg.cnt - 1'b1;
      if (!st_reg.osc_irq_enable)
        st_next.mode = LPMRS_DHALT;
    end

    // a reset from any source leaves low power through the delay
    // reset wake
    if ((wdg_rst_req || lvd_rst_req || st_reg.pin_low) && (st_reg.mode != LPMRS_RUN))
    begin
      st_next.mode = LPMRS_DELAY;
      st_next.cnt = delay_len(st_reg.long_delay);
      st_next.wake_irq = 1'b0;
    end

    // ********** axi4-lite write path **********
    if (s_axi_awvalid && !st_reg.aw_got)
    begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_got)
    begin
      st_next.w_got = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    do_write = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    wd = st_reg.w_data;
    if (do_write)
    begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = 2'b00;
      if (addr_is(st_reg.aw_addr, LPMRS_CTRL_OFF))
      begin
        if (st_reg.w_strb[0])
          st_next.osc_irq_enable = wd[LPMRS_CTRL_OIE_BIT];
      end
      else if (addr_is(st_reg.aw_addr, LPMRS_IRQ_EN_OFF))
      begin
        if (st_reg.w_strb[0])
          st_next.ev_en = wd[LPMRS_EV_W-1:0];
      end
      else if (addr_is(st_reg.aw_addr, LPMRS_IRQ_CLR_OFF))
      begin
        if (st_reg.w_strb[0])
          st_next.ev_stat = st_reg.ev_stat & ~wd[LPMRS_EV_W-1:0];
      end
      else if (addr_is(st_reg.aw_addr, LPMRS_FLAG_CLR_OFF))
      begin
        // software clears flags; a same-cycle set above wins
        if (st_reg.w_strb[0] && wd[LPMRS_FLAG_LVD_BIT] && !lvd_rst_req)
          st_next.lvd_flag = 1'b0;
        if (st_reg.w_strb[0] && wd[LPMRS_FLAG_WDG_BIT] && !(wdg_rst_req && opt_lvd_en))
          st_next.wdg_flag = 1'b0;
      end
      else if (!addr_is(st_reg.aw_addr, LPMRS_STAT_OFF)
               && !addr_is(st_reg.aw_addr, LPMRS_IRQ_STAT_OFF))
        st_next.bresp = 2'b10;
    end
    if (st_reg.bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;

    // sticky events: set wins over clear
    st_next.ev_stat = st_next.ev_stat | ev_set;

    // ********** axi4-lite read path **********
    if (s_axi_arvalid && !st_reg.rvalid)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp = 2'b00;
      st_next.rdata = '0;
      if (addr_is(s_axi_araddr, LPMRS_CTRL_OFF))
        st_next.rdata = {30'h0000_0000, st_reg.long_delay, st_reg.osc_irq_enable};
      else if (addr_is(s_axi_araddr, LPMRS_STAT_OFF))
        st_next.rdata = {24'h00_0000, 1'b0, st_reg.mode, 2'b00, st_reg.wdg_flag,
                         st_reg.lvd_flag};
      else if (addr_is(s_axi_araddr, LPMRS_IRQ_STAT_OFF))
        st_next.rdata = {28'h000_0000, st_reg.ev_stat};
      else if (addr_is(s_axi_araddr, LPMRS_IRQ_EN_OFF))
        st_next.rdata = {28'h000_0000, st_reg.ev_en};
      else if (!addr_is(s_axi_araddr, LPMRS_IRQ_CLR_OFF)
               && !addr_is(s_axi_araddr, LPMRS_FLAG_CLR_OFF))
        st_next.rresp = 2'b10;
    end
    else if (st_reg.rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.mode <= LPMRS_RUN;
      st_reg.osc_irq_enable <= LPMRS_CTRL_OIE_RST;
      st_reg.pin_sync <= 3'b111;
    end
    else
      st_reg <= st_next;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // pin driven low during pulse
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe = (st_reg.pulse != '0);
  assign ctl.rtc_clk_en = (st_reg.mode != LPMRS_HALT) && (st_reg.mode != LPMRS_DHALT);
  assign ctl.periph_clk_en = (st_reg.mode == LPMRS_RUN);
  assign ctl.cpu_clk_en = (st_reg.mode == LPMRS_RUN);
  assign ctl.cc_force = (st_reg.mode == LPMRS_AHALT);
  assign ctl.cc_i_val = LPMRS_CC_I_ACTIVE;
  assign ctl.wdg_block = (st_reg.mode == LPMRS_AHALT) && st_reg.osc_irq_enable;
  assign ctl.service_irq = (st_reg.mode == LPMRS_RUN) && st_reg.wake_irq;
  assign ctl.fetch_reset = (st_reg.mode == LPMRS_RUN) && !st_reg.wake_irq;
  assign irq = |(st_reg.ev_stat & st_reg.ev_en);
  // bus handshakes
  assign s_axi_awready = !st_reg.aw_got;
  assign s_axi_wready = !st_reg.w_got;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = st_reg.rdata;

endmodule // lpmrs_ctrl
`default_nettype wire

// file: testbench/lpmrs_checker.sv
// concurrent checks on the power mode controller ports
`timescale 1ns/1ps
`default_nettype none
module lpmrs_checker
  import lpmrs_pkg::*;
#(
  parameter int RST_PULSE_CYC = 2
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // strap and sources
  input wire logic opt_lvd_en,
  input wire lpmrs_src_t src,
  // pin and core controls
  input wire logic rst_pin_oe,
  input wire lpmrs_ctl_t ctl,
  // read data channel
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ****
  // helper counters
  // ****
  logic [12:0] oe_cnt_reg;  // cycles the pin has been pulled low
  logic [12:0] off_cnt_reg;  // cycles the core clock has been off
  // counters restart whenever their condition drops
  always_ff @(posedge mclk)
  begin
    oe_cnt_reg <= (rst_n && rst_pin_oe) ? oe_cnt_reg + 13'h0001 : 13'h0000;
    off_cnt_reg <= (rst_n && !ctl.cpu_clk_en) ? off_cnt_reg + 13'h0001 : 13'h0000;
  end
  // ****
  // wake sequences
  // ****
  sequence s_ahalt_irq;
    ctl.cc_force && (src.rtc_irq || src.ext_irq);
  endsequence
  sequence s_resumed;
    ctl.cpu_clk_en && ctl.service_irq;
  endsequence
  a_enter_on_halt: assert property ($rose(ctl.cc_force) |-> $past(src.halt_exec))
    else $error("active halt entered without halt");
  a_ahalt_clocks: assert property (ctl.cc_force |->
    ctl.rtc_clk_en && !ctl.periph_clk_en && !ctl.cpu_clk_en)
    else $error("wrong clocks in active halt");
  a_cc_forced: assert property (ctl.cc_force |-> ctl.cc_i_val == LPMRS_CC_I_ACTIVE)
    else $error("interrupt bits not forced");
  a_irq_wake_fast: assert property (s_ahalt_irq |=> s_resumed)
    else $error("interrupt wake not immediate");
  a_wdg_blocked: assert property (ctl.wdg_block && src.wdg_underflow && !src.lvd_low
    |=> !$rose(rst_pin_oe))
    else $error("watchdog reset in active halt");
  a_wdg_drive: assert property (src.wdg_underflow && src.wdg_active && !ctl.wdg_block
    |=> rst_pin_oe)
    else $error("watchdog did not pull pin");
  a_pulse_width: assert property ($fell(rst_pin_oe) |-> oe_cnt_reg >= RST_PULSE_CYC)
    else $error("reset pulse too short");
  a_lvd_drive: assert property (opt_lvd_en && src.lvd_low |=> rst_pin_oe)
    else $error("low supply did not pull pin");
  a_reset_delay: assert property ($rose(ctl.cpu_clk_en) && ctl.fetch_reset
    |-> off_cnt_reg >= LPMRS_DELAY_SHORT_CYC - 4)
    else $error("reset exit without delay");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule  // lpmrs_checker
bind lpmrs_ctrl lpmrs_checker #(.RST_PULSE_CYC(RST_PULSE_CYC)) u_chk (.mclk, .rst_n,
  .opt_lvd_en, .src, .rst_pin_oe, .ctl, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// file: testbench/lpmrs_core_model.sv
// processor core and reset pin model facing the power mode controller
`timescale 1ns/1ps
`default_nettype none
module lpmrs_core_model
  import lpmrs_pkg::*;
(
  // clock
  input wire logic mclk,
  // bench commands
  input wire logic want_halt,
  input wire logic ext_rst,
  // controller side
  input wire lpmrs_ctl_t ctl,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  output logic halt_exec,
  output logic rst_pin_in
);
  // pin has a pull-up: low only while the button or the controller pulls it
  assign rst_pin_in = !(ext_rst || (rst_pin_oe && !rst_pin_out));
  // a stopped core executes nothing, so halt issues only while clocked
  always_ff @(posedge mclk)
    halt_exec <= want_halt && ctl.cpu_clk_en;
endmodule  // lpmrs_core_model
`default_nettype wire

// file: testbench/lpmrs_ctrl_tb_top.sv
// register level testbench for the power mode controller
`timescale 1ns/1ps
`default_nettype none
module lpmrs_ctrl_tb_top
  import lpmrs_pkg::*;
;
  localparam int PULSE = 4;  // short pulse keeps the run brief
  logic mclk, rst_n, lvd_en, long_dly, want_halt, ext_rst;
  logic rtc, ext, wuf, wact, low_voltage_detector, halt_w, pin_in, pin_out, pin_oe, irq;
  lpmrs_src_t src;
  lpmrs_ctl_t ctl;
  logic [7:0] awaddr, araddr, d;
  logic [31:0] wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, r;
  int err_total, cmp_count;
  assign src = {halt_w, rtc, ext, wuf, wact, low_voltage_detector};
  lpmrs_ctrl #(.RST_PULSE_CYC(PULSE)) DUT (.mclk(mclk), .rst_n(rst_n),
    .opt_lvd_en(lvd_en), .opt_long_delay(long_dly), .src(src), .rst_pin_in(pin_in),
    .rst_pin_out(pin_out), .rst_pin_oe(pin_oe), .ctl(ctl), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  lpmrs_core_model u_core (.mclk(mclk), .want_halt(want_halt), .ext_rst(ext_rst),
    .ctl(ctl), .rst_pin_out(pin_out), .rst_pin_oe(pin_oe), .halt_exec(halt_w),
    .rst_pin_in(pin_in));
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ****
  // bus and check tasks
  // ****
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h00_0000, v};
    {awvalid, wvalid, bready} <= 3'h7;
    do
    begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do
    begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    d = rdata[7:0];
    r = rresp;
  endtask
  task automatic rdc(input string n, input logic [7:0] a, m, e);
    rd(a);
    chk("rresp", 8'h00, {6'h00, r});
    chk(n, e, d & m);
  endtask
  // core issues a halt, then the mode settles
  task automatic halt();
    @(posedge mclk);
    want_halt <= 1'b1;
    @(posedge mclk);
    want_halt <= 1'b0;
    cyc(3);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog: the run needs well under 10000 cycles
  initial
  begin
    #400000;
    err_total++;
    wrap_up();
  end
  // ****
  // test sequence
  // ****
  initial
  begin
    err_total = 0;
    cmp_count = 0;
    {rst_n, lvd_en, long_dly, want_halt, ext_rst, rtc, ext, wuf, wact, low_voltage_detector} = '0;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    cyc(2);
    rst_n <= 1'b1;
    rdc("ctrl", 8'h00, 8'h03, 8'h00);
    rdc("stat", 8'h04, 8'h73, 8'h00);
    rd(8'h18);
    chk("unmapped", 8'h02, {6'h00, r});
    wr(8'h04, 8'hFF);
    chk("bresp_ro", 8'h00, {6'h00, r});
    rdc("stat_ro", 8'h04, 8'h73, 8'h00);
    wr(8'h18, 8'h00);
    chk("bresp_bad", 8'h02, {6'h00, r});
    // watchdog with detector off: pin pulled, flag meaningless and kept clear
    wact <= 1'b1;
    wuf <= 1'b1;
    cyc(1);
    wuf <= 1'b0;
    cyc(1);
    chk("oe_wdg", 8'h01, {7'h00, pin_oe});
    cyc(300);
    rdc("wdg_flag_off", 8'h04, 8'h02, 8'h00);
    chk("irq_masked", 8'h00, {7'h00, irq});
    wr(8'h10, 8'h0F);
    cyc(1);
    chk("irq_on", 8'h01, {7'h00, irq});
    wr(8'h0C, 8'h0F);
    cyc(1);
    chk("irq_clr", 8'h00, {7'h00, irq});
    // plain halt, woken by interrupt after the short delay
    halt();
    rdc("halt_mode", 8'h04, 8'h70, 8'h10);
    ext <= 1'b1;
    cyc(1);
    ext <= 1'b0;
    cyc(200);
    chk("halt_dly", 8'h00, {7'h00, ctl.cpu_clk_en});
    cyc(100);
    chk("halt_run", 8'h01, {7'h00, ctl.cpu_clk_en});
    // active halt woken by rtc, then by another interrupt with oie cleared early
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h00, 8'h01);
      halt();
      rdc("ahalt_mode", 8'h04, 8'h70, 8'h20);
      wuf <= 1'b1;
      cyc(1);
      wuf <= 1'b0;
      cyc(2);
      chk("wdg_blocked", 8'h00, {7'h00, pin_oe});
      {rtc, ext} <= i ? 2'h1 : 2'h2;
      cyc(1);
      {rtc, ext} <= 2'h0;
      cyc(1);
      chk("wake_fast", 8'h03, {6'h00, ctl.cpu_clk_en, ctl.service_irq});
      if (i == 1)
      begin
        wr(8'h00, 8'h00);
        rdc("drop_halt", 8'h04, 8'h70, 8'h40);
      end
      cyc(300);
    end
    rdc("back_run", 8'h04, 8'h70, 8'h00);
    // reset pin while in active halt: delayed exit through the reset vector
    wr(8'h00, 8'h01);
    halt();
    ext_rst <= 1'b1;
    cyc(6);
    ext_rst <= 1'b0;
    cyc(100);
    chk("rst_dly", 8'h00, {7'h00, ctl.cpu_clk_en});
    cyc(250);
    chk("rst_vec", 8'h03, {6'h00, ctl.cpu_clk_en, ctl.fetch_reset});
    // supply failure stays recorded through later resets
    lvd_en <= 1'b1;
    low_voltage_detector <= 1'b1;
    cyc(3);
    chk("oe_lvd", 8'h01, {7'h00, pin_oe});
    low_voltage_detector <= 1'b0;
    cyc(300);
    wuf <= 1'b1;
    cyc(1);
    wuf <= 1'b0;
    cyc(300);
    rdc("flags", 8'h04, 8'h03, 8'h03);
    ext_rst <= 1'b1;
    cyc(6);
    ext_rst <= 1'b0;
    cyc(300);
    rdc("lvd_kept", 8'h04, 8'h01, 8'h01);
    wr(8'h14, 8'h03);
    rdc("flag_clr", 8'h04, 8'h03, 8'h00);
    rdc("clr_wo", 8'h14, 8'hFF, 8'h00);
    // long delay option after a fresh reset
    rst_n <= 1'b0;
    long_dly <= 1'b1;
    cyc(2);
    rst_n <= 1'b1;
    rdc("long_opt", 8'h00, 8'h02, 8'h02);
    halt();
    ext <= 1'b1;
    cyc(1);
    ext <= 1'b0;
    cyc(3000);
    chk("long_dly", 8'h00, {7'h00, ctl.cpu_clk_en});
    cyc(1200);
    chk("long_run", 8'h01, {7'h00, ctl.cpu_clk_en});
    wrap_up();
  end
endmodule  // lpmrs_ctrl_tb_top
`default_nettype wire
